// ### logic/sadc_consts.svh
/*
 * Constants for the serial converter readout link: frame positions,
 * result width and timing figures for both ends of the link.
 * Assumes the including file is compiled after this header only once.
 */
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SADC_RES_W 16
`define SADC_SMPL_FALLS 3'h5
`define SADC_MARK_RISE 6'h06
`define SADC_REV_BITS 6'h0f
`define SADC_FULL_BITS 5'h10

// ----------------------------------------------------------------------
// Timing figures and the cycle counts derived from them
// ----------------------------------------------------------------------
`define SADC_CLK_KHZ 25000
`define SADC_MAX_RATE_KHZ 100
`define SADC_SCLK_MAX_KHZ 2400
`define SADC_CYC_MIN_CLKS \
    ((`SADC_CLK_KHZ + `SADC_MAX_RATE_KHZ - 1) / `SADC_MAX_RATE_KHZ)
`define SADC_HALF_MIN_CLKS \
    ((`SADC_CLK_KHZ + 2 * `SADC_SCLK_MAX_KHZ - 1) / (2 * `SADC_SCLK_MAX_KHZ))
`define SADC_LAT_HALF_MIN 6
`define SADC_HALF_DEF 8

`endif

// ### logic/sadc_pkg.sv
/*
 * Types shared by the two ends of the serial converter readout link.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package sadc_pkg;

    // ------------------------------------------------------------------
    // Converter end states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        DEV_IDLE = 6'h01,
        DEV_SAMPLE = 6'h02,
        DEV_MARK = 6'h04,
        DEV_MSB = 6'h08,
        DEV_REV = 6'h10,
        DEV_DONE = 6'h20
    } sadc_dev_state_t;

    // ------------------------------------------------------------------
    // Host end states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        HST_IDLE = 3'h1,
        HST_RUN = 3'h2,
        HST_GAP = 3'h4
    } sadc_hst_state_t;

endpackage : sadc_pkg

`default_nettype wire

// ### logic/sadc_link_if.sv
/*
 * Three-wire link between the serial host and the converter end.
 * Assumes the data line idles high through a pull-up when undriven.
 */
`timescale 1ns/1ps
`default_nettype none

interface sadc_link_if;
    // Host-driven select and bit clock.
    logic conv_sel_n;
    logic serial_bit_clock;
    // Converter data pin as output value and enable.
    logic data_out;
    logic data_oe;
    // Resolved line level; the pull-up holds it high when released.
    logic data_line;

    assign data_line = data_oe ? data_out : 1'b1;

    modport device (
        input conv_sel_n,
        input serial_bit_clock,
        output data_out,
        output data_oe
    );

    modport host (
        output conv_sel_n,
        output serial_bit_clock,
        input data_line
    );
endinterface : sadc_link_if

`default_nettype wire

// ### logic/sadc_sync_edge.sv
/*
 * Two-stage synchroniser with edge detection on the synchronised level.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sadc_sync_edge #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Raw input
    input wire logic async_in,
    // Synchronised results
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    // Only the second stage feeds the edge detector, never the first.
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= INIT;
            sync_q <= INIT;
            prev_q <= INIT;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Edges are seen in the same cycle that the synchronised level moves.
    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule : sadc_sync_edge

`default_nettype wire

// ### logic/sadc_device_end.sv
/*
 * Converter end of the serial readout link: samples the host's select
 * and bit clock, captures a conversion result and shifts it out on the
 * data pin with marker, forward and reversed bit order.
 * Assumes the bit clock half period spans at least six clk cycles and
 * that sample_value holds the result of the analog stage, in two's
 * complement, stable from the select falling edge to the fifth fall.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"

module sadc_device_end #(
    parameter int RES_W = `SADC_RES_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link to the host
    sadc_link_if.device link,
    // Analog stage result
    input wire logic [RES_W-1:0] sample_value,
    // Status
    output logic power_down,
    output logic conv_busy
);
    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    localparam int IDX_W = $clog2(RES_W);

    generate
        if (RES_W != `SADC_RES_W) begin : g_bad_width
            $error("sadc_device_end: result width must be sixteen");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Link input synchronisers
    // ------------------------------------------------------------------
    logic sclk_fall;
    logic sel_level;
    logic sel_fall;

    // The bit clock idles low. The select stage also starts low, so a
    // select already low when reset ends shows no fall and starts
    // nothing; the false rise that may follow reset is not used.
    sadc_sync_edge #(
        .INIT(1'b0)
    ) u_sclk_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(link.serial_bit_clock),
        .level(),
        .rise(),
        .fall(sclk_fall)
    );

    sadc_sync_edge #(
        .INIT(1'b0)
    ) u_sel_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(link.conv_sel_n),
        .level(sel_level),
        .rise(),
        .fall(sel_fall)
    );

    // ------------------------------------------------------------------
    // Bit selection
    // ------------------------------------------------------------------
    // Picks one result bit; used for both shift directions.
    function automatic logic bit_at(input logic [RES_W-1:0] word,
                                    input logic [IDX_W-1:0] idx);
        bit_at = word[idx];
    endfunction : bit_at

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    sadc_pkg::sadc_dev_state_t state_q;
    sadc_pkg::sadc_dev_state_t state_d;
    logic [2:0] fall_cnt_q;
    logic [2:0] fall_cnt_d;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] idx_d;
    logic [RES_W-1:0] res_q;
    logic [RES_W-1:0] res_d;
    logic dout_q;
    logic dout_d;
    logic oe_q;
    logic oe_d;
    logic pd_q;
    logic pd_d;
    logic busy_q;
    logic busy_d;

    // Next-state logic. The select level is checked before any clock
    // edge so that a raised select always wins over a bit clock fall.
    always_comb begin
        state_d = state_q;
        fall_cnt_d = fall_cnt_q;
        idx_d = idx_q;
        res_d = res_q;
        dout_d = dout_q;
        oe_d = oe_q;
        pd_d = pd_q;
        busy_d = busy_q;
        if (sel_level) begin
            // Select high: abandon, release the pin, power down.
            state_d = sadc_pkg::DEV_IDLE;
            oe_d = 1'b0;
            dout_d = 1'b0;
            pd_d = 1'b1;
            busy_d = 1'b0;
        end else begin
            unique case (state_q)
                sadc_pkg::DEV_IDLE: begin
                    // Only a fresh fall starts; a held-low select that
                    // ended a frame never restarts one.
                    if (sel_fall) begin
                        state_d = sadc_pkg::DEV_SAMPLE;
                        fall_cnt_d = 3'h0;
                        pd_d = 1'b0;
                        busy_d = 1'b1;
                    end
                end
                sadc_pkg::DEV_SAMPLE: begin
                    if (sclk_fall) begin
                        if (fall_cnt_q == `SADC_SMPL_FALLS - 3'h1) begin
                            // Sampling ends; capture this conversion's
                            // result and present the low marker.
                            state_d = sadc_pkg::DEV_MARK;
                            res_d = sample_value;
                            oe_d = 1'b1;
                            dout_d = 1'b0;
                        end else begin
                            fall_cnt_d = fall_cnt_q + 3'h1;
                        end
                    end
                end
                sadc_pkg::DEV_MARK: begin
                    if (sclk_fall) begin
                        state_d = sadc_pkg::DEV_MSB;
                        idx_d = IDX_W'(RES_W - 1);
                        dout_d = bit_at(res_q, IDX_W'(RES_W - 1));
                    end
                end
                sadc_pkg::DEV_MSB: begin
                    if (sclk_fall) begin
                        if (idx_q == '0) begin
                            // Least significant bit sent; the reversed
                            // run starts at bit one, bit zero not twice.
                            state_d = sadc_pkg::DEV_REV;
                            idx_d = IDX_W'(1);
                            dout_d = bit_at(res_q, IDX_W'(1));
                            pd_d = 1'b1;
                            busy_d = 1'b0;
                        end else begin
                            idx_d = idx_q - IDX_W'(1);
                            dout_d = bit_at(res_q, idx_q - IDX_W'(1));
                        end
                    end
                end
                sadc_pkg::DEV_REV: begin
                    if (sclk_fall) begin
                        if (idx_q == IDX_W'(RES_W - 1)) begin
                            state_d = sadc_pkg::DEV_DONE;
                            oe_d = 1'b0;
                            dout_d = 1'b0;
                        end else begin
                            idx_d = idx_q + IDX_W'(1);
                            dout_d = bit_at(res_q, idx_q + IDX_W'(1));
                        end
                    end
                end
                sadc_pkg::DEV_DONE: begin
                    // Bit clock edges have no effect here.
                    state_d = sadc_pkg::DEV_DONE;
                end
                default: begin
                    state_d = sadc_pkg::DEV_IDLE;
                    oe_d = 1'b0;
                    pd_d = 1'b1;
                    busy_d = 1'b0;
                end
            endcase
        end
    end

    // Registers of the frame sequencer.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= sadc_pkg::DEV_IDLE;
            fall_cnt_q <= 3'h0;
            idx_q <= '0;
            res_q <= '0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            pd_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            fall_cnt_q <= fall_cnt_d;
            idx_q <= idx_d;
            res_q <= res_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            pd_q <= pd_d;
            busy_q <= busy_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // All outputs are flops; data lags the pin's fall by three clk.
    assign link.data_out = dout_q;
    assign link.data_oe = oe_q;
    assign power_down = pd_q;
    assign conv_busy = busy_q;
endmodule : sadc_device_end

`default_nettype wire

// ### logic/sadc_host_end.sv
/*
 * Host end of the serial readout link: makes the bit clock by dividing
 * clk, frames one conversion per start, collects the forward result,
 * optionally checks the reversed copy, and paces frames.
 * Assumes the converter updates data within three clk of a clock fall.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"

module sadc_host_end #(
    parameter int HALF = `SADC_HALF_DEF,
    parameter int CYC_MIN = `SADC_CYC_MIN_CLKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link to the converter
    sadc_link_if.host link,
    // Command
    input wire logic start,
    input wire logic [4:0] bits_wanted,
    input wire logic read_reversed,
    // Answer
    output logic ready,
    output logic [15:0] result,
    output logic result_valid,
    output logic marker_err,
    output logic reverse_err
);
    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    generate
        if (HALF < `SADC_HALF_MIN_CLKS || HALF < `SADC_LAT_HALF_MIN ||
            HALF > 255) begin : g_bad_half
            $error("sadc_host_end: HALF out of range");
        end
        if (CYC_MIN < `SADC_CYC_MIN_CLKS || CYC_MIN > 4095)
        begin : g_bad_cyc
            $error("sadc_host_end: CYC_MIN out of range");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Data line synchroniser
    // ------------------------------------------------------------------
    logic line;

    sadc_sync_edge #(
        .INIT(1'b1)
    ) u_line_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(link.data_line),
        .level(line),
        .rise(),
        .fall()
    );

    // ------------------------------------------------------------------
    // Frame control
    // ------------------------------------------------------------------
    sadc_pkg::sadc_hst_state_t state_q;
    sadc_pkg::sadc_hst_state_t state_d;
    logic [7:0] half_q;
    logic [7:0] half_d;
    logic [11:0] cyc_q;
    logic [11:0] cyc_d;
    logic [5:0] rise_q;
    logic [5:0] rise_d;
    logic [5:0] last_q;
    logic [5:0] last_d;
    logic [4:0] want_q;
    logic [4:0] want_d;
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic sclk_q;
    logic sclk_d;
    logic sel_n_q;
    logic sel_n_d;
    logic rdy_q;
    logic rdy_d;
    logic [15:0] res_q;
    logic [15:0] res_d;
    logic val_q;
    logic val_d;
    logic merr_q;
    logic merr_d;
    logic rerr_q;
    logic rerr_d;

    // Sequencing; data is taken when the bit clock is driven high, the last bit when select is raised instead.
    always_comb begin
        logic [5:0] k;
        logic [4:0] w;
        k = rise_q + 6'h01;
        w = (bits_wanted == 5'h00 || bits_wanted > `SADC_FULL_BITS) ?
            `SADC_FULL_BITS : bits_wanted;
        state_d = state_q;
        half_d = half_q;
        cyc_d = (cyc_q == 12'hfff) ? cyc_q : cyc_q + 12'h001;
        rise_d = rise_q;
        last_d = last_q;
        want_d = want_q;
        shift_d = shift_q;
        sclk_d = sclk_q;
        sel_n_d = sel_n_q;
        rdy_d = rdy_q;
        res_d = res_q;
        val_d = 1'b0;
        merr_d = merr_q;
        rerr_d = rerr_q;
        unique case (state_q)
            sadc_pkg::HST_IDLE: begin
                if (start) begin
                    // Clock already low when select falls.
                    state_d = sadc_pkg::HST_RUN;
                    sel_n_d = 1'b0;
                    sclk_d = 1'b0;
                    half_d = 8'h00;
                    cyc_d = 12'h000;
                    rise_d = 6'h00;
                    want_d = w;
                    // The reversed copy is only read after a full
                    // forward run; a short cycle has no copy to check.
                    last_d = `SADC_MARK_RISE + {1'b0, w} +
                             ((read_reversed && w == `SADC_FULL_BITS) ?
                              `SADC_REV_BITS : 6'h00);
                    shift_d = 16'h0000;
                    merr_d = 1'b0;
                    rerr_d = 1'b0;
                    rdy_d = 1'b0;
                end
            end
            sadc_pkg::HST_RUN: begin
                half_d = half_q + 8'h01;
                if (half_q == 8'(HALF - 1)) begin
                    half_d = 8'h00;
                    sclk_d = ~sclk_q;
                    if (!sclk_q) begin
                        // Rising edge: sample the settled data bit.
                        rise_d = k;
                        if (k == `SADC_MARK_RISE && line) begin
                            merr_d = 1'b1;
                        end
                        if (k > `SADC_MARK_RISE &&
                            k <= `SADC_MARK_RISE + {1'b0, want_q}) begin
                            shift_d = {shift_q[14:0], line};
                        end
                        if (k > `SADC_MARK_RISE + 6'h10 &&
                            line != shift_q[4'(k - `SADC_MARK_RISE -
                                               6'h10)]) begin
                            rerr_d = 1'b1;
                        end
                        if (k == last_q) begin
                            // Short cycle or full frame ends here.
                            state_d = sadc_pkg::HST_GAP;
                            sel_n_d = 1'b1;
                            sclk_d = 1'b0;
                            res_d = (k > `SADC_MARK_RISE + 6'h10) ?
                                    shift_q :
                                    {shift_q[14:0], line} <<
                                    (`SADC_FULL_BITS - want_q);
                            val_d = 1'b1;
                        end
                    end
                end
            end
            sadc_pkg::HST_GAP: begin
                // Hold select high until the frame period is used up.
                if (cyc_q >= 12'(CYC_MIN - 1) && cyc_q >= 12'(HALF)) begin
                    state_d = sadc_pkg::HST_IDLE;
                    rdy_d = 1'b1;
                end
            end
            default: begin
                state_d = sadc_pkg::HST_IDLE;
                sel_n_d = 1'b1;
                sclk_d = 1'b0;
                rdy_d = 1'b1;
            end
        endcase
    end

    // Registers of the frame control.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= sadc_pkg::HST_IDLE;
            half_q <= 8'h00;
            cyc_q <= 12'h000;
            rise_q <= 6'h00;
            last_q <= 6'h00;
            want_q <= 5'h00;
            shift_q <= 16'h0000;
            sclk_q <= 1'b0;
            sel_n_q <= 1'b1;
            rdy_q <= 1'b1;
            res_q <= 16'h0000;
            val_q <= 1'b0;
            merr_q <= 1'b0;
            rerr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            half_q <= half_d;
            cyc_q <= cyc_d;
            rise_q <= rise_d;
            last_q <= last_d;
            want_q <= want_d;
            shift_q <= shift_d;
            sclk_q <= sclk_d;
            sel_n_q <= sel_n_d;
            rdy_q <= rdy_d;
            res_q <= res_d;
            val_q <= val_d;
            merr_q <= merr_d;
            rerr_q <= rerr_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.serial_bit_clock = sclk_q;
    assign link.conv_sel_n = sel_n_q;
    assign ready = rdy_q;
    assign result = res_q;
    assign result_valid = val_q;
    assign marker_err = merr_q;
    assign reverse_err = rerr_q;
endmodule : sadc_host_end

`default_nettype wire

// ### test/sadc_link_sva.sv
/* Checker for the serial readout link, fed with the interface wires.
   Assumes a host half period of eight clk and a device lag of 3 clk. */
`timescale 1ns/1ps
`default_nettype none

module sadc_link_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link wires
    input wire logic conv_sel_n,
    input wire logic serial_bit_clock,
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic data_line
);
    // ------------------------------------------------------------
    // Link properties
    // ------------------------------------------------------------
    // One domain, so reset masks every check from here.
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // The marker must outlast half a bit period.
    sequence s_mark;
        !data_out [*8];
    endsequence
    // The host gives the device a low clock phase to see select fall.
    sequence s_quiet;
        !serial_bit_clock [*8];
    endsequence
    a_marker_low: assert property ($rose(data_oe) |-> s_mark)
        else $error("marker bit not low");
    a_enable_on_fall: assert property ($rose(data_oe) |->
        !serial_bit_clock && !conv_sel_n)
        else $error("pin enabled outside a low clock phase");
    a_data_on_fall: assert property (data_oe && $past(data_oe) &&
        $changed(data_out) |-> !serial_bit_clock)
        else $error("data moved while the bit clock was high");
    a_release_sel: assert property (conv_sel_n [*4] |-> !data_oe)
        else $error("pin still driven after select rose");
    a_start_quiet: assert property ($fell(conv_sel_n) |-> s_quiet)
        else $error("bit clock rose too soon after select fell");
    a_sample_hold: assert property ($fell(conv_sel_n) |->
        ##1 !data_oe [*8])
        else $error("pin driven during the sample phase");
    a_clk_idle: assert property (conv_sel_n |-> !serial_bit_clock)
        else $error("bit clock high while deselected");
    a_frame_len: assert property ($rose(data_oe) |->
        ##[1:600] !data_oe)
        else $error("pin never released after the frame");
endmodule : sadc_link_sva

`default_nettype wire

// ### test/test_sar_adc_serial_readout.sv
/* Bench joining host and converter ends through the link interface.
   Assumes the design's default half period and frame pacing. */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", nm, e, a); end end

module test_sar_adc_serial_readout;
    typedef struct {
        logic [15:0] smp;
        logic [4:0] n;
        logic rev;
        logic [15:0] exp;
    } sadc_row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [4:0] bits_wanted = 5'h00;
    logic read_reversed = 1'b0;
    logic [15:0] sample_value = 16'h0000;
    logic ready, result_valid, marker_err, reverse_err;
    logic power_down, conv_busy, sclk_q;
    logic [15:0] result;
    logic [31:0] wire_q;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    sadc_row_t rows [6] = '{
        '{16'h7fff, 5'h00, 1'b1, 16'h7fff}, '{16'h0000, 5'h10, 1'b1, 16'h0000},
        '{16'hffff, 5'h10, 1'b0, 16'hffff}, '{16'h8000, 5'h11, 1'b1, 16'h8000},
        '{16'ha5c3, 5'h03, 1'b0, 16'ha000}, '{16'hc3a5, 5'h01, 1'b0, 16'h8000}};

    // ------------------------------------------------------------
    // Ends, link and checker
    // ------------------------------------------------------------
    sadc_link_if sadc_link_if_i ();
    sadc_host_end sadc_host_end_i (.clk(clk), .sys_rst(sys_rst),
        .link(sadc_link_if_i), .start(start), .bits_wanted(bits_wanted),
        .read_reversed(read_reversed), .ready(ready), .result(result),
        .result_valid(result_valid), .marker_err(marker_err),
        .reverse_err(reverse_err));
    sadc_device_end sadc_device_end_i (.clk(clk), .sys_rst(sys_rst),
        .link(sadc_link_if_i), .sample_value(sample_value),
        .power_down(power_down), .conv_busy(conv_busy));
    sadc_link_sva sadc_link_sva_i (.clk(clk), .sys_rst(sys_rst),
        .conv_sel_n(sadc_link_if_i.conv_sel_n),
        .serial_bit_clock(sadc_link_if_i.serial_bit_clock),
        .data_out(sadc_link_if_i.data_out), .data_oe(sadc_link_if_i.data_oe),
        .data_line(sadc_link_if_i.data_line));

    // Clock, and a cycle ceiling well above eight frames plus gaps.
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    // Wire monitor: shift in the line level at each bit clock rise.
    always @(posedge clk) begin
        sclk_q <= sadc_link_if_i.serial_bit_clock;
        if (sadc_link_if_i.serial_bit_clock && !sclk_q) begin
            wire_q <= {wire_q[30:0], sadc_link_if_i.data_line};
        end
    end

    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // One framed conversion; waits are bounded so a hang still reports.
    task automatic run(input sadc_row_t r);
        logic [15:0] rv;
        int w;
        rv = {<<{r.smp}};
        sample_value = r.smp;
        bits_wanted = r.n;
        read_reversed = r.rev;
        for (w = 0; w < 2000 && ready !== 1'b1; w++) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (w = 0; w < 2000 && result_valid !== 1'b1; w++) @(negedge clk);
        `CHK("result", r.exp, result)
        `CHK("marker", 1'b0, marker_err)
        `CHK("reverse", 1'b0, reverse_err)
        // The host reads the last reversed bit as select rises, with no
        // clock rise, so the wire shows rises five to thirty-six.
        if (r.rev) begin
            `CHK("wire", {1'b1, 1'b0, r.smp, rv[14:1]}, wire_q)
        end
        repeat (4) @(negedge clk);
        `CHK("power_down", 1'b1, power_down)
        `CHK("busy", 1'b0, conv_busy)
        `CHK("line", 1'b1, sadc_link_if_i.data_line)
    endtask : run

    // Table first, then a reset dropped into a live frame.
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        foreach (rows[i]) run(rows[i]);
        sample_value = 16'h1234;
        bits_wanted = 5'h00;
        read_reversed = 1'b1;
        repeat (300) if (ready !== 1'b1) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (200) @(negedge clk);
        `CHK("oe_live", 1'b1, sadc_link_if_i.data_oe)
        `CHK("busy_live", 1'b1, conv_busy)
        `CHK("pd_live", 1'b0, power_down)
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("oe_rst", 1'b0, sadc_link_if_i.data_oe)
        `CHK("pd_rst", 1'b1, power_down)
        `CHK("busy_rst", 1'b0, conv_busy)
        sys_rst = 1'b0;
        run('{16'h4321, 5'h10, 1'b1, 16'h4321});
        final_report();
    end
endmodule : test_sar_adc_serial_readout

`default_nettype wire
